// *** dv/igcb_bus_model.sv ***
// Behavioural two-wire master that addresses the unit
`timescale 1ns/1ps
module igcb_bus_model (
   input wire logic ref_clk,
   input wire logic scl,
   input wire logic sda,
   output logic scl_pull,
   output logic sda_pull
);
   int half = 8; // Clock phase in cycles
   logic acked = 1'b0; // Ninth bit pulled low
   // Lines released at start
   initial begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end
   // Wait n cycles
   task automatic idle(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // One clock, data set while low, stretch tolerated
   task automatic pulse(input logic drop);
      int k;
      idle(2);
      sda_pull <= drop;
      idle(half);
      scl_pull <= 1'b0;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (!scl && k < 2000);
      // Clock held low too long
      if (k >= 2000) begin
         testbench.error_cnt++;
         testbench.final_report();
      end
      idle(half);
      acked = !sda;
      scl_pull <= 1'b1;
   endtask
   // Data falls while clock high
   task automatic start();
      sda_pull <= 1'b1;
      idle(half);
      scl_pull <= 1'b1;
   endtask
   // Eight bits, top bit first, then acknowledge clock
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) pulse(!b[i]);
      pulse(1'b0);
   endtask
   // Data rises while clock high
   task automatic stop();
      idle(2);
      sda_pull <= 1'b1;
      idle(half);
      scl_pull <= 1'b0;
      idle(half);
      sda_pull <= 1'b0;
      idle(half);
   endtask
endmodule

// *** dv/igcb_checker.sv ***
// Port-level checks for the two-wire unit
`timescale 1ns/1ps
`include "igcb_params.svh"
module igcb_checker (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic scl_i,
   input wire logic scl_o,
   input wire logic scl_oe,
   input wire logic sda_i,
   input wire logic sda_o,
   input wire logic sda_oe
);
   // =============================
   // Mode bits seen on the bus
   logic [1:0] mode_reg; // Mirrored mode
   logic [1:0] mode_next; // Its next value
   logic wr_done; // Answered write
   assign wr_done = psel && penable && pready && pwrite;
   // Take mode from finished writes
   always_comb begin
      mode_next = (wr_done && paddr == `IGCB_OFF_MODE) ? pwdata[1:0] : mode_reg;
   end
   // Mode register
   always_ff @(posedge ref_clk) begin
      mode_reg <= reset ? 2'h0 : mode_next;
   end
   // =============================
   // Properties
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   AST_APB_ANSWER: assert property (psel && penable && !pready |=> pready)
      else $error("access not answered in the next cycle");
   AST_APB_PULSE: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   AST_UNMAPPED: assert property (pready && paddr > `IGCB_OFF_MODE |-> pslverr)
      else $error("unmapped access without error");
   AST_READ_UPPER: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
   AST_OPEN_DRAIN: assert property (scl_o == 1'b0 && sda_o == 1'b0)
      else $error("pin driven high");
   AST_RESET_QUIET: assert property ($fell(reset) |-> !scl_oe && !sda_oe && !pready)
      else $error("outputs active after reset");
   AST_START_ON_WRITE: assert property (
      wr_done && paddr == `IGCB_OFF_BUF && mode_reg[0] |-> ##[1:600] scl_oe)
      else $error("buffer write did not start the clock");
   AST_HALF_BOUND: assert property ($rose(scl_oe) |-> ##[1:600] !scl_oe)
      else $error("clock low phase did not end");
   AST_SDA_STEADY: assert property ($past(scl_i) && scl_i |-> $stable(sda_oe))
      else $error("data pin changed while clock high");
endmodule
bind igcb_top igcb_checker chk (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe);

// *** dv/testbench.sv ***
// Self-checking bench for the two-wire unit
`timescale 1ns/1ps
`include "igcb_params.svh"
module testbench;
   // =============================
   // Offsets and wiring
   localparam logic [7:0] CT = `IGCB_OFF_CTRL, OW = `IGCB_OFF_OWN, BU = `IGCB_OFF_BUF;
   localparam logic [7:0] ST = `IGCB_OFF_STAT, MO = `IGCB_OFF_MODE;
   logic ref_clk, reset, psel, penable, pwrite; // Clock, reset and bus controls
   logic [7:0] paddr; // Bus address
   logic [31:0] pwdata; // Bus write data
   logic [31:0] prdata;
   logic pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, scl_pull, sda_pull, scl, sda;
   logic [31:0] rd; // Last read word
   logic err; // Last error bit
   logic [8:0] frame; // Bits seen on clock rises
   int per_a, per_b, hi;
   int error_cnt = 0;
   int checks = 0;
   always #2.5 ref_clk = ~ref_clk;
   // Pull-ups on both wires
   assign scl = !((scl_oe && !scl_o) || scl_pull);
   assign sda = !((sda_oe && !sda_o) || sda_pull);
   igcb_top dut (.ref_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .scl_i(scl), .scl_o, .scl_oe, .sda_i(sda), .sda_o, .sda_oe);
   igcb_bus_model bm (.ref_clk, .scl, .sda, .scl_pull, .sda_pull);
   // =============================
   // Tasks
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One bus transfer, held until ready
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) begin
         error_cnt++;
         final_report();
      end
   endtask
   // Read and compare
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // Collect nine clock rises and the first period
   task automatic get_frame(output logic [8:0] bits, output int per);
      int k, n, t0;
      logic prev;
      n = 0;
      k = 0;
      t0 = 0;
      per = 0;
      bits = 9'h0;
      prev = scl;
      while (n < 9 && k < 5000) begin
         @(posedge ref_clk);
         k++;
         if (!prev && scl) begin
            bits = {bits[7:0], sda};
            n++;
            if (n == 1) t0 = k;
            if (n == 2) per = k - t0;
         end
         prev = scl;
      end
      if (n < 9) begin
         error_cnt++;
         final_report();
      end
   endtask
   // =============================
   // Main sequence
   initial begin
      ref_clk = 1'b0;
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (8) @(posedge ref_clk);
      reset <= 1'b0;
      rc(CT, 32'h0);
      rc(OW, 32'h0);
      rc(MO, 32'h0);
      rc(ST, 32'h0);
      rc(8'h20, 32'h0);
      chk(32'(err), 32'h1);
      $display("test reset done");
      apb(1'b1, CT, 32'h80);
      bm.start();
      bm.send_byte(8'h00);
      chk(32'(bm.acked), 32'h1);
      bm.send_byte(8'h3c);
      bm.stop();
      rc(ST, 32'h5);
      rc(BU, 32'h0);
      rc(BU, 32'h3c);
      apb(1'b1, ST, 32'h4);
      rc(ST, 32'h0);
      $display("test general call done");
      apb(1'b1, CT, 32'h0);
      apb(1'b1, OW, 32'h42);
      bm.start();
      bm.send_byte(8'h00);
      chk(32'(bm.acked), 32'h0);
      bm.stop();
      rc(ST, 32'h0);
      bm.start();
      bm.send_byte(8'h42);
      for (int i = 1; i < 8; i++) bm.send_byte(8'(i * 17));
      rc(ST, 32'hd);
      fork
         bm.send_byte(8'hee);
         begin
            repeat (200) @(posedge ref_clk);
            chk(32'(scl), 32'h0);
            rc(BU, 32'h42);
         end
      join
      bm.stop();
      for (int i = 1; i < 8; i++) rc(BU, 32'(i * 17));
      rc(BU, 32'hee);
      rc(ST, 32'h4);
      $display("test own address and queue done");
      apb(1'b1, MO, 32'h2);
      apb(1'b1, OW, 32'hf2);
      bm.start();
      bm.send_byte(8'hf2);
      apb(1'b0, ST, 32'h0);
      chk(rd & 32'h2, 32'h2);
      apb(1'b1, OW, 32'h5a);
      apb(1'b0, ST, 32'h0);
      chk(rd & 32'h2, 32'h0);
      bm.send_byte(8'h5a);
      apb(1'b0, ST, 32'h0);
      chk(rd & 32'h2, 32'h2);
      bm.stop();
      rc(BU, 32'hf2);
      rc(BU, 32'h5a);
      apb(1'b1, ST, 32'h4);
      apb(1'b1, OW, 32'hf2);
      apb(1'b1, CT, 32'h80);
      bm.half = 12;
      bm.start();
      bm.send_byte(8'h00);
      bm.send_byte(8'h99);
      chk(32'(bm.acked), 32'h1);
      bm.stop();
      apb(1'b0, ST, 32'h0);
      chk(rd & 32'h2, 32'h0);
      rc(BU, 32'h0);
      rc(BU, 32'h99);
      $display("test ten-bit done");
      apb(1'b1, MO, 32'h1);
      apb(1'b1, OW, 32'h83);
      apb(1'b1, BU, 32'ha5);
      get_frame(frame, per_a);
      chk(32'(frame), 32'h14b);
      apb(1'b1, OW, 32'h01);
      apb(1'b1, BU, 32'ha5);
      fork
         get_frame(frame, per_b);
         apb(1'b1, BU, 32'hff);
      join
      chk(32'(frame), 32'h14b);
      chk(32'(per_a - per_b), 32'h8);
      hi = 0;
      repeat (100) @(posedge ref_clk) hi += int'(scl_oe);
      chk(32'(hi), 32'h0);
      $display("test master done");
      final_report();
   end
endmodule

// *** src/igcb_fifo.sv ***
// Small synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module igcb_fifo import igcb_pkg::*; #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   // =====================================================================
   // Whole state in one record
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] count;
   } igcb_fifo_state_t;

   igcb_fifo_state_t fifo_reg; // Registered state
   igcb_fifo_state_t fifo_next; // Next state
   logic push; // Write accepted
   logic pop; // Read accepted

   // Honest flags from the occupancy count
   assign in_ready = (fifo_reg.count != DEPTH[AW:0]);
   assign out_valid = (fifo_reg.count != '0);
   assign out_data = fifo_reg.mem[fifo_reg.rp];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   // Pointer and count update
   always_comb begin
      fifo_next = fifo_reg;
      if (push) begin
         fifo_next.mem[fifo_reg.wp] = in_data;
         fifo_next.wp = (fifo_reg.wp == AW'(DEPTH - 1)) ? '0 : fifo_reg.wp + 1'b1;
      end
      if (pop) begin
         fifo_next.rp = (fifo_reg.rp == AW'(DEPTH - 1)) ? '0 : fifo_reg.rp + 1'b1;
      end
      if (push & ~pop) begin
         fifo_next.count = fifo_reg.count + 1'b1;
      end else if (pop & ~push) begin
         fifo_next.count = fifo_reg.count - 1'b1;
      end
   end

   // State register
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         fifo_reg <= '0;
      end else begin
         fifo_reg <= fifo_next;
      end
   end

endmodule

// *** src/igcb_params.svh ***
// Constants for the general call recognizer and rate generator
// =====================================================================
// Notes on behaviour
// - All-zero byte with write bit is general call
// - General call honoured only while enable bit set
// - Shift eight bits, compare own and general
// - Match: buffer, full flag, flag at ninth fall
// - Ten-bit mode sets update flag; software rewrites
// - Ten-bit general call: no update, data follows
// - Master reload from low seven own bits
// - Buffer write starts the rate generator
// - Generator counts to zero, reloads; rests at zero after byte
// - Decrement on second and fourth phases
// - Master mode reloads generator automatically
// - Finished operation stops clock, SCL holds
`ifndef IGCB_PARAMS_SVH
`define IGCB_PARAMS_SVH

// =====================================================================
// Register byte offsets
`define IGCB_OFF_CTRL 8'h00
`define IGCB_OFF_OWN 8'h04
`define IGCB_OFF_BUF 8'h08
`define IGCB_OFF_STAT 8'h0c
`define IGCB_OFF_MODE 8'h10

// =====================================================================
// Field positions
`define IGCB_GENERAL_CALL_ENABLE_BIT 7
`define IGCB_STAT_BF_BIT 0
`define IGCB_STAT_UA_BIT 1
`define IGCB_STAT_IF_BIT 2
`define IGCB_STAT_FULL_BIT 3
`define IGCB_MODE_MASTER_BIT 0
`define IGCB_MODE_TEN_BIT 1
`define IGCB_RELOAD_BITS 7

// =====================================================================
// Reset values and fixed codes
`define IGCB_RST_CTRL 8'h00
`define IGCB_RST_OWN 8'h00
`define IGCB_RST_MODE 2'h0
`define IGCB_GC_ADDR 8'h00
`define IGCB_TEN_PREFIX 5'h1e

// =====================================================================
// Timing counts
`define IGCB_BYTE_LAST 4'h7
`define IGCB_ACK_CNT 4'h8
`define IGCB_ACK_END 4'h9
`define IGCB_HALF_LAST 5'h11
`define IGCB_DATA_HALVES 5'h10
`define IGCB_PHASE_Q2 2'h1
`define IGCB_PHASE_Q4 2'h3
`define IGCB_FIFO_WIDTH 8
`define IGCB_FIFO_DEPTH 8

`endif

// *** src/igcb_pkg.sv ***
// Types shared by the general call recognizer and rate generator
package igcb_pkg;

   // =====================================================================
   // Slave receive states
   typedef enum logic [3:0] {
      IGCB_S_IDLE = 4'h1,
      IGCB_S_BYTE = 4'h2,
      IGCB_S_ACK = 4'h4,
      IGCB_S_IGNORE = 4'h8
   } igcb_slave_t;

   // =====================================================================
   // Master clocking states
   typedef enum logic [1:0] {
      IGCB_M_IDLE = 2'h1,
      IGCB_M_RUN = 2'h2
   } igcb_master_t;

   // =====================================================================
   // State of the top module, apart from the receive FIFO
   typedef struct packed {
      logic scl_m;
      logic scl_s;
      logic scl_d;
      logic sda_m;
      logic sda_s;
      logic sda_d;
      logic [7:0] ctrl;
      logic [7:0] own;
      logic [1:0] mode;
      logic ua;
      logic iflag;
      logic bf;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      igcb_slave_t st;
      logic [3:0] cnt;
      logic [7:0] shift;
      logic is_addr;
      logic want_low;
      logic ack_drv;
      logic stretch;
      logic pend;
      logic [7:0] pend_byte;
      igcb_master_t m_st;
      logic [1:0] phase;
      logic [6:0] rate_generator;
      logic [4:0] half;
      logic [7:0] txsh;
      logic m_scl_low;
      logic m_sda_low;
      logic scl_oe;
      logic sda_oe;
   } igcb_state_t;

endpackage

// *** src/igcb_top.sv ***
// Two-wire slave with general call support and master rate generator
`timescale 1ns/1ps
`include "igcb_params.svh"
module igcb_top import igcb_pkg::*; (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);

   // =====================================================================
   // State and helper signals
   igcb_state_t state_reg; // Registered state
   igcb_state_t state_next; // Next state
   logic fifo_in_ready; // Receive FIFO can take a byte
   logic fifo_out_valid; // Receive FIFO holds a byte
   logic [7:0] fifo_out_data; // Oldest received byte
   logic fifo_pop; // Software read of the buffer
   logic scl_rise; // Synchronised SCL rising edge
   logic scl_fall; // Synchronised SCL falling edge
   logic start_det; // Start or repeated start seen
   logic stop_det; // Stop seen
   logic q_tick; // Second or fourth phase pulse
   logic apb_setup; // First access cycle
   logic apb_done; // Completing access cycle
   logic [7:0] rx_byte; // Byte including the current bit
   logic gc_hit; // General call recognised
   logic [6:0] reload_val; // Rate generator reload

   // =====================================================================
   // Bus edge and condition detection on the synchronised pins
   assign scl_rise = state_reg.scl_s & ~state_reg.scl_d;
   assign scl_fall = ~state_reg.scl_s & state_reg.scl_d;
   assign start_det = state_reg.scl_s & state_reg.scl_d & state_reg.sda_d & ~state_reg.sda_s;
   assign stop_det = state_reg.scl_s & state_reg.scl_d & ~state_reg.sda_d & state_reg.sda_s;
   assign rx_byte = {state_reg.shift[6:0], state_reg.sda_s};
   // All-zero write address, honoured only while enabled
   assign gc_hit = (rx_byte == `IGCB_GC_ADDR) & state_reg.ctrl[`IGCB_GENERAL_CALL_ENABLE_BIT];
   assign reload_val = state_reg.own[`IGCB_RELOAD_BITS-1:0];

   // Decrement pulses on phases two and four of each instruction cycle
   assign q_tick = (state_reg.phase == `IGCB_PHASE_Q2) | (state_reg.phase == `IGCB_PHASE_Q4);

   // APB phases; the answer comes one cycle into the access phase
   assign apb_setup = psel & penable & ~state_reg.pready;
   assign apb_done = psel & penable & state_reg.pready;
   assign fifo_pop = apb_done & ~pwrite & (paddr == `IGCB_OFF_BUF) & fifo_out_valid;

   // =====================================================================
   // Receive FIFO between the shifter and the buffer register
   igcb_fifo #(
      .WIDTH(`IGCB_FIFO_WIDTH),
      .DEPTH(`IGCB_FIFO_DEPTH)
   ) u_rx_fifo (
      .ref_clk(ref_clk),
      .reset(reset),
      .in_valid(state_reg.pend),
      .in_ready(fifo_in_ready),
      .in_data(state_reg.pend_byte),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data)
   );

   // =====================================================================
   // Next-state logic for bus slave, receiver and rate generator
   always_comb begin
      state_next = state_reg;

      // Two-stage pin synchronisers and one delayed copy
      state_next.scl_m = scl_i;
      state_next.scl_s = state_reg.scl_m;
      state_next.scl_d = state_reg.scl_s;
      state_next.sda_m = sda_i;
      state_next.sda_s = state_reg.sda_m;
      state_next.sda_d = state_reg.sda_s;

      // Phase divider, one step per reference cycle
      state_next.phase = state_reg.phase + 2'h1;

      // ---------------------------------------------------------------
      // APB answer: read data and error captured on the first cycle
      state_next.pready = apb_setup;
      if (apb_setup) begin
         state_next.pslverr = 1'b0;
         state_next.prdata = 32'h0;
         case (paddr)
            `IGCB_OFF_CTRL: state_next.prdata[7:0] = state_reg.ctrl;
            `IGCB_OFF_OWN: state_next.prdata[7:0] = state_reg.own;
            `IGCB_OFF_BUF: state_next.prdata[7:0] = fifo_out_data; // Head byte tells address kind
            `IGCB_OFF_STAT: begin
               state_next.prdata[`IGCB_STAT_BF_BIT] = state_reg.bf;
               state_next.prdata[`IGCB_STAT_UA_BIT] = state_reg.ua;
               state_next.prdata[`IGCB_STAT_IF_BIT] = state_reg.iflag;
               state_next.prdata[`IGCB_STAT_FULL_BIT] = ~fifo_in_ready;
            end
            `IGCB_OFF_MODE: state_next.prdata[1:0] = state_reg.mode;
            default: state_next.pslverr = 1'b1; // Unmapped address
         endcase
      end

      // Writes take effect at the completing edge
      if (apb_done & pwrite) begin
         case (paddr)
            `IGCB_OFF_CTRL: state_next.ctrl = pwdata[7:0];
            `IGCB_OFF_OWN: begin
               state_next.own = pwdata[7:0];
               state_next.ua = 1'b0; // Rewrite answers the update request
            end
            `IGCB_OFF_STAT: begin
               if (pwdata[`IGCB_STAT_IF_BIT]) begin
                  state_next.iflag = 1'b0; // Write one to clear
               end
            end
            `IGCB_OFF_MODE: state_next.mode = pwdata[1:0];
            `IGCB_OFF_BUF: begin
               // Master transmit start; ignored while busy
               if (state_reg.mode[`IGCB_MODE_MASTER_BIT] && state_reg.m_st == IGCB_M_IDLE) begin
                  state_next.txsh = pwdata[7:0];
                  state_next.rate_generator = reload_val;
                  state_next.half = 5'h0;
                  state_next.m_st = IGCB_M_RUN;
               end
            end
            default: state_next.ctrl = state_reg.ctrl; // Unmapped, no effect
         endcase
      end

      // Full flag follows the receive buffer contents
      state_next.bf = fifo_out_valid;

      // Pending byte leaves once the FIFO accepts it
      if (state_reg.pend & fifo_in_ready) begin
         state_next.pend = 1'b0;
      end

      // ---------------------------------------------------------------
      // Slave receiver, active only outside master mode
      if (state_reg.mode[`IGCB_MODE_MASTER_BIT]) begin
         state_next.st = IGCB_S_IDLE;
         state_next.ack_drv = 1'b0;
      end else if (start_det) begin
         // Address byte follows every start
         state_next.st = IGCB_S_BYTE;
         state_next.cnt = 4'h0;
         state_next.is_addr = 1'b1;
         state_next.want_low = 1'b0;
         state_next.ack_drv = 1'b0;
      end else if (stop_det) begin
         state_next.st = IGCB_S_IDLE;
         state_next.ack_drv = 1'b0;
      end else begin
         case (state_reg.st)
            IGCB_S_IDLE: begin
               state_next.ack_drv = 1'b0; // Wait for a start
            end
            IGCB_S_BYTE: begin
               if (scl_rise) begin
                  // Sample one bit, MSB first
                  state_next.shift = rx_byte;
                  state_next.cnt = state_reg.cnt + 4'h1;
                  if (state_reg.cnt == `IGCB_BYTE_LAST) begin
                     state_next.st = IGCB_S_IGNORE; // Default: no match
                     if (state_reg.is_addr) begin
                        if (gc_hit) begin
                           // General call, no second half even in ten-bit mode
                           state_next.st = IGCB_S_ACK;
                           state_next.is_addr = 1'b0;
                        end else if (rx_byte[0]) begin
                           state_next.st = IGCB_S_IGNORE; // Reads are not served
                        end else if (state_reg.mode[`IGCB_MODE_TEN_BIT]) begin
                           if (rx_byte[7:3] == `IGCB_TEN_PREFIX && rx_byte[7:1] == state_reg.own[7:1]) begin
                              state_next.st = IGCB_S_ACK;
                              state_next.ua = 1'b1;
                              state_next.want_low = 1'b1;
                              state_next.is_addr = 1'b0;
                           end
                        end else if (rx_byte[7:1] == state_reg.own[7:1]) begin
                           // Own address; a zero byte only matches here
                           state_next.st = IGCB_S_ACK;
                           state_next.is_addr = 1'b0;
                        end
                     end else if (state_reg.want_low) begin
                        // Second half of a ten-bit address
                        if (rx_byte == state_reg.own) begin
                           state_next.st = IGCB_S_ACK;
                           state_next.ua = 1'b1;
                           state_next.want_low = 1'b0;
                        end
                     end else begin
                        state_next.st = IGCB_S_ACK; // Data byte
                     end
                     // Matched byte is copied toward the buffer
                     if (state_next.st == IGCB_S_ACK) begin
                        state_next.pend = 1'b1;
                        state_next.pend_byte = rx_byte;
                     end
                  end
               end
            end
            IGCB_S_ACK: begin
               if (scl_fall) begin
                  if (state_reg.cnt == `IGCB_ACK_CNT) begin
                     // Eighth fall: pull SDA for acknowledge
                     state_next.ack_drv = 1'b1;
                     state_next.cnt = `IGCB_ACK_END;
                  end else begin
                     // Ninth fall: release and raise the flag
                     state_next.ack_drv = 1'b0;
                     state_next.iflag = 1'b1;
                     state_next.cnt = 4'h0;
                     state_next.st = IGCB_S_BYTE;
                  end
               end
            end
            IGCB_S_IGNORE: begin
               state_next.ack_drv = 1'b0; // No flags for unmatched bytes
            end
            default: begin
               state_next.st = IGCB_S_IDLE;
            end
         endcase
      end

      // Hold SCL low while a byte waits for FIFO room
      state_next.stretch = state_next.pend & (state_reg.st == IGCB_S_ACK) & ~state_reg.scl_s;

      // ---------------------------------------------------------------
      // Master rate generator and clocking of one byte plus acknowledge
      case (state_reg.m_st)
         IGCB_M_IDLE: begin
            state_next.m_scl_low = state_reg.m_scl_low; // Hold last SCL state
         end
         IGCB_M_RUN: begin
            if (q_tick) begin
               if (state_reg.rate_generator != 7'h0) begin
                  state_next.rate_generator = state_reg.rate_generator - 7'h1;
               end else if (state_reg.half == `IGCB_HALF_LAST) begin
                  // Acknowledge clock done: stop, generator rests at zero
                  state_next.m_scl_low = 1'b0;
                  state_next.m_st = IGCB_M_IDLE;
                  state_next.rate_generator = 7'h0;
               end else begin
                  // Rollover: automatic reload and next half period
                  state_next.rate_generator = reload_val;
                  state_next.half = state_reg.half + 5'h1;
                  if (~state_reg.half[0]) begin
                     state_next.m_scl_low = 1'b1;
                     if (state_reg.half < `IGCB_DATA_HALVES) begin
                        state_next.m_sda_low = ~state_reg.txsh[7];
                        state_next.txsh = {state_reg.txsh[6:0], 1'b0};
                     end else begin
                        state_next.m_sda_low = 1'b0; // Release for acknowledge
                     end
                  end else begin
                     state_next.m_scl_low = 1'b0;
                  end
               end
            end
         end
         default: begin
            state_next.m_st = IGCB_M_IDLE;
         end
      endcase

      // Open-drain enables, combined for both roles
      state_next.scl_oe = state_next.stretch | state_next.m_scl_low;
      state_next.sda_oe = state_next.ack_drv | state_next.m_sda_low;
   end

   // =====================================================================
   // State register with synchronous reset
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_reg <= '0;
         state_reg.scl_m <= 1'b1;
         state_reg.scl_s <= 1'b1;
         state_reg.scl_d <= 1'b1;
         state_reg.sda_m <= 1'b1;
         state_reg.sda_s <= 1'b1;
         state_reg.sda_d <= 1'b1;
         state_reg.ctrl <= `IGCB_RST_CTRL;
         state_reg.own <= `IGCB_RST_OWN;
         state_reg.mode <= `IGCB_RST_MODE;
         state_reg.st <= IGCB_S_IDLE;
         state_reg.m_st <= IGCB_M_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // =====================================================================
   // Outputs straight from the state register
   assign prdata = state_reg.prdata;
   assign pready = state_reg.pready;
   assign pslverr = state_reg.pslverr;
   assign scl_o = 1'b0 & state_reg.scl_oe; // Open drain: drives low only
   assign sda_o = 1'b0 & state_reg.sda_oe;
   assign scl_oe = state_reg.scl_oe;
   assign sda_oe = state_reg.sda_oe;

endmodule
